//--- hw/chsq_sequencer.sv
// Purpose: Hardscan sequencer with serial control register and 256-entry scan list.
// Assumes: Frame line high while a pseudo-slot is addressed; trigger and link are asynchronous pins.
// Notes: Scan control lines are active low; an empty list leaves all lines inactive.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1: Control register loads only at pseudo-slot 13, eight bits MSB first.
// RL2: Rewind bit written low returns read position to first entry.
// RL3: List is read only while read-enable is high, pausing between entries; the code's preload (RL6) still loads the current entry with read-enable low.
// RL4: Single-pass stops after the last entry; otherwise wraps to first.
// RL5: Reset bit written low empties the list and clears scan state.
// RL6: Preload bit written low loads counter from current list entry.
// RL7: Scan-control enable clear forces every scan-control line high.
// RL8: Clock-enable clear makes the sequencer ignore the trigger line.
// RL9: List entries load only at pseudo-slot 14, sixteen bits MSB first.
// RL10: Each finished entry write appends at the list tail in order; the code drops the write once the list already holds 256 entries.
// RL11: The list holds up to 256 entries.
// RL12: Slot field is bits 10 to 7, selecting field value plus one.
// RL13: Count field bits 6 to 0 give count plus one samples.
// RL14: Counter decrements per trigger edge; terminal count advances to next entry.
module chsq_sequencer (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] slot_select,
    input wire logic frame_line,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic trigger_line,
    output logic [15:0] scan_ctrl_line_n,
    output logic [7:0] hardscan_control,
    output logic [8:0] entry_total,
    output logic scan_running
);
    logic [1:0] frame_sync;
    logic [1:0] sclk_sync;
    logic [1:0] sdata_sync;
    logic [1:0] trig_sync;
    logic [3:0] slot_sync0;
    logic [3:0] slot_sync1;
    logic frame_q;
    logic sclk_q;
    logic trig_q;
    logic sclk_rise;
    logic trig_rise;
    logic frame_end;
    logic [15:0] rx_word;
    logic [4:0] rx_count;
    logic rx_done;
    logic [3:0] frame_slot;
    logic [3:0] next_frame_slot;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            frame_sync <= 2'h0;
            sclk_sync <= 2'h3;
            sdata_sync <= 2'h0;
            trig_sync <= 2'h0;
            slot_sync0 <= 4'h0;
            slot_sync1 <= 4'h0;
            frame_q <= 1'b0;
            sclk_q <= 1'b1;
            trig_q <= 1'b0;
        end else begin
            frame_sync <= {frame_sync[0], frame_line};
            sclk_sync <= {sclk_sync[0], serial_clock};
            sdata_sync <= {sdata_sync[0], serial_data};
            trig_sync <= {trig_sync[0], trigger_line};
            slot_sync0 <= slot_select;
            slot_sync1 <= slot_sync0;
            frame_q <= frame_sync[1];
            sclk_q <= sclk_sync[1];
            trig_q <= trig_sync[1];
        end
    end

    assign sclk_rise = sclk_sync[1] && !sclk_q;
    assign trig_rise = trig_sync[1] && !trig_q;
    assign frame_end = frame_q && !frame_sync[1];

    // Slot is latched at frame start so a later slot change cannot retarget a word.
    always_comb begin
        next_frame_slot = frame_slot;
        if (frame_sync[1] && !frame_q) begin
            next_frame_slot = slot_sync1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            frame_slot <= 4'h0;
        end else begin
            frame_slot <= next_frame_slot;
        end
    end

    chsq_shift_rx u_rx (
        .clock(clock),
        .rstn(rstn),
        .sclk_rise(sclk_rise),
        .sdata(sdata_sync[1]),
        .frame_active(frame_sync[1]),
        .frame_end(frame_end),
        .word(rx_word),
        .bit_count(rx_count),
        .word_done(rx_done)
    );

    logic ctrl_write;
    logic entry_write;
    chsq_pkg::chsq_ctrl_s ctrl;

    // RL1 control word select
    assign ctrl_write = rx_done && (frame_slot == chsq_pkg::CTRL_SLOT)
        && (rx_count == 5'(chsq_pkg::CTRL_BITS));
    // RL9 entry word select
    assign entry_write = rx_done && (frame_slot == chsq_pkg::ENTRY_SLOT)
        && (rx_count == 5'(chsq_pkg::ENTRY_BITS));

    logic [7:0] next_control;
    logic [chsq_pkg::PTR_W-1:0] wr_ptr;
    logic [chsq_pkg::PTR_W-1:0] rd_ptr;
    logic [8:0] next_entry_total;
    logic [chsq_pkg::PTR_W-1:0] next_wr_ptr;
    logic [chsq_pkg::PTR_W-1:0] next_rd_ptr;
    logic [6:0] counter;
    logic [6:0] next_counter;
    logic [3:0] cur_slot;
    logic [3:0] next_cur_slot;
    logic active;
    logic next_active;
    logic pause;
    logic next_pause;
    // RL11 list storage
    chsq_pkg::chsq_entry_s list_mem [chsq_pkg::LIST_DEPTH];
    chsq_pkg::chsq_entry_s head;
    chsq_pkg::chsq_entry_s new_entry;
    logic at_last;

    assign ctrl = chsq_pkg::chsq_ctrl_s'(hardscan_control[6:0]);
    assign head = list_mem[rd_ptr];
    // RL12 slot and count fields
    assign new_entry = '{slot: rx_word[chsq_pkg::SLOT_HI:chsq_pkg::SLOT_LO],
        count: rx_word[chsq_pkg::CNT_HI:chsq_pkg::CNT_LO]};
    assign at_last = ({1'b0, rd_ptr} + 9'h001) >= entry_total;

    always_comb begin
        next_control = hardscan_control;
        if (ctrl_write) begin
            next_control = rx_word[7:0];
        end
    end

    // RL10 append at tail
    always_ff @(posedge clock) begin
        if (entry_write && entry_total < 9'(chsq_pkg::LIST_DEPTH)) begin
            list_mem[wr_ptr] <= new_entry;
        end
    end

    always_comb begin
        next_entry_total = entry_total;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_counter = counter;
        next_cur_slot = cur_slot;
        next_active = active;
        next_pause = 1'b0;
        if (entry_write && entry_total < 9'(chsq_pkg::LIST_DEPTH)) begin
            next_wr_ptr = wr_ptr + 8'h01;
            next_entry_total = entry_total + 9'h001;
        end
        // A control write in the pause cycle must not lose the entry just taken.
        if (pause) begin
            // RL3 take next entry after pause
            next_counter = head.count;
            next_cur_slot = head.slot;
        end
        if (ctrl_write) begin
            if (!rx_word[chsq_pkg::CTRL_PRELOAD] && entry_total != 9'h000) begin
                // RL6 preload from head
                next_counter = head.count;
                next_cur_slot = head.slot;
                next_active = 1'b1;
            end
            if (!rx_word[chsq_pkg::CTRL_REWIND]) begin
                // RL2 rewind read position
                next_rd_ptr = 8'h00;
                next_active = 1'b0;
            end
            if (!rx_word[chsq_pkg::CTRL_RESET]) begin
                // RL5 empty list and stop
                next_wr_ptr = 8'h00;
                next_rd_ptr = 8'h00;
                next_entry_total = 9'h000;
                next_counter = 7'h00;
                next_active = 1'b0;
            end
        // RL8 trigger gated by enable
        end else if (!pause && active && ctrl.trigger_clock_enable && ctrl.read_en && trig_rise) begin
            // RL14 count down per trigger
            if (counter != 7'h00) begin
                next_counter = counter - 7'h01;
            end else if (at_last && ctrl.once) begin
                // RL4 single pass stops
                next_active = 1'b0;
            end else begin
                // RL4 wrap or advance
                next_rd_ptr = at_last ? 8'h00 : rd_ptr + 8'h01;
                next_pause = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            hardscan_control <= chsq_pkg::CTRL_RESET_VALUE;
            wr_ptr <= 8'h00;
            rd_ptr <= 8'h00;
            entry_total <= 9'h000;
            counter <= 7'h00;
            cur_slot <= 4'h0;
            active <= 1'b0;
            pause <= 1'b0;
        end else begin
            hardscan_control <= next_control;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            entry_total <= next_entry_total;
            counter <= next_counter;
            cur_slot <= next_cur_slot;
            active <= next_active;
            pause <= next_pause;
        end
    end

    assign scan_running = active;

    // Slot field value plus one names the module; slot 0 itself is never scanned.
    genvar gi;
    generate
        for (gi = 0; gi < chsq_pkg::NUM_SLOTS; gi++) begin : g_line
            logic next_line_n;
            logic line_n;
            always_comb begin
                // RL7 lines gated by enable
                // RL13 held for count plus one
                next_line_n = !(ctrl.scan_ctrl_lines_enable && active
                    && (5'(cur_slot) + 5'h01 == 5'(gi)));
            end
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    line_n <= 1'b1;
                end else begin
                    line_n <= next_line_n;
                end
            end
            assign scan_ctrl_line_n[gi] = line_n;
        end
    endgenerate
endmodule : chsq_sequencer
`default_nettype wire

//--- hw/chsq_pkg.sv
// Purpose: Shared constants and types for the chassis hardscan sequencer.
// Assumes: One 20 MHz clock; serial link and trigger line pass two-flop synchronisers in the sequencer.
// Notes: Bit positions of the control and entry words live here.
package chsq_pkg;
    localparam int unsigned CLOCK_HZ = 20000000;
    localparam logic [3:0] CTRL_SLOT = 4'hd;
    localparam logic [3:0] ENTRY_SLOT = 4'he;
    localparam int unsigned CTRL_BITS = 8;
    localparam int unsigned ENTRY_BITS = 16;
    localparam int unsigned LIST_DEPTH = 256;
    localparam int unsigned PTR_W = 8;
    localparam int unsigned NUM_SLOTS = 16;
    localparam int unsigned CTRL_REWIND = 6;
    localparam int unsigned CTRL_READ = 5;
    localparam int unsigned CTRL_ONCE = 4;
    localparam int unsigned CTRL_RESET = 3;
    localparam int unsigned CTRL_PRELOAD = 2;
    localparam int unsigned CTRL_SCANEN = 1;
    localparam int unsigned CTRL_TRIGGER_CLOCK_ENABLE = 0;
    localparam int unsigned SLOT_HI = 10;
    localparam int unsigned SLOT_LO = 7;
    localparam int unsigned CNT_HI = 6;
    localparam int unsigned CNT_LO = 0;
    localparam logic [7:0] CTRL_RESET_VALUE = 8'h4c;

    typedef struct packed {
        logic [3:0] slot;
        logic [6:0] count;
    } chsq_entry_s;

    typedef struct packed {
        logic rewind_n;
        logic read_en;
        logic once;
        logic scan_reset_n;
        logic preload_n;
        logic scan_ctrl_lines_enable;
        logic trigger_clock_enable;
    } chsq_ctrl_s;
endpackage : chsq_pkg

//--- hw/chsq_shift_rx.sv
// Purpose: Serial receiver that shifts link data MSB first and reports each finished word.
// Assumes: Link lines already synchronised; shift on rising edge of the serial clock.
// Notes: The word is complete on the falling edge of the frame line; partial words are flagged too, with their bit count.
`timescale 1ns/100ps
`default_nettype none
module chsq_shift_rx (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sclk_rise,
    input wire logic sdata,
    input wire logic frame_active,
    input wire logic frame_end,
    output logic [15:0] word,
    output logic [4:0] bit_count,
    output logic word_done
);
    logic [15:0] next_word;
    logic [4:0] next_bit_count;
    logic next_word_done;

    always_comb begin
        next_word = word;
        next_bit_count = bit_count;
        next_word_done = 1'b0;
        if (frame_end) begin
            next_word_done = 1'b1;
        end else if (!frame_active) begin
            next_bit_count = 5'h00;
        end else if (sclk_rise) begin
            next_word = {word[14:0], sdata};
            if (bit_count != 5'h1f) begin
                next_bit_count = bit_count + 5'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            word <= 16'h0000;
            bit_count <= 5'h00;
            word_done <= 1'b0;
        end else begin
            word <= next_word;
            bit_count <= next_bit_count;
            word_done <= next_word_done;
        end
    end
endmodule : chsq_shift_rx
`default_nettype wire

//--- verification/chsq_seq_properties.sv
// Purpose: Port-level checks for the hardscan sequencer.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Control effects are judged from the registered control copy.
`timescale 1ns/100ps
`default_nettype none
module chsq_seq_properties (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] slot_select,
    input wire logic frame_line,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic trigger_line,
    input wire logic [15:0] scan_ctrl_line_n,
    input wire logic [7:0] hardscan_control,
    input wire logic [8:0] entry_total,
    input wire logic scan_running
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence ctrl_write;
        $changed(hardscan_control);
    endsequence
    sequence ctrl_quiet;
        $stable(hardscan_control) [*4];
    endsequence
    chk_reset_state:
    assert property (disable iff (1'b0) !rstn |=> hardscan_control == 8'h4c && entry_total == 9'h000 && !scan_running)
        else $error("reset state wrong");
    chk_frame_hold:
    assert property (frame_line [*8] |-> $stable(hardscan_control) && $stable(entry_total))
        else $error("register changed inside a frame");
    chk_list_bound:
    assert property (entry_total <= 9'h100) else $error("list count above depth");
    chk_list_append:
    assert property ($changed(entry_total) |-> entry_total == $past(entry_total) + 9'h001 || entry_total == 9'h000)
        else $error("list count jumped");
    chk_rewind_stop:
    assert property (ctrl_write ##0 !hardscan_control[6] |-> ##[0:2] !scan_running) else $error("rewind did not stop");
    chk_reset_bit:
    assert property (ctrl_write ##0 !hardscan_control[3] |-> ##[0:2] (entry_total == 9'h000 && !scan_running))
        else $error("reset bit did not empty list");
    chk_preload_start:
    assert property (ctrl_write ##0 (hardscan_control[6] && hardscan_control[3] && !hardscan_control[2]
        && entry_total != 9'h000) |-> ##[0:2] scan_running)
        else $error("preload did not start");
    chk_lines_off:
    assert property (!hardscan_control[1] [*2] |-> scan_ctrl_line_n == 16'hffff) else $error("line low while disabled");
    chk_one_line:
    assert property ($onehot0(~scan_ctrl_line_n) && scan_ctrl_line_n[0]) else $error("bad scan line pattern");
    chk_trigger_gate:
    assert property (ctrl_quiet ##0 !(hardscan_control[0] && hardscan_control[5]) |-> $stable(scan_ctrl_line_n))
        else $error("advanced while gated");
endmodule : chsq_seq_properties
bind chsq_sequencer chsq_seq_properties u_chsq_seq_properties (.clock(clock), .rstn(rstn),
    .slot_select(slot_select), .frame_line(frame_line), .serial_clock(serial_clock), .serial_data(serial_data),
    .trigger_line(trigger_line), .scan_ctrl_line_n(scan_ctrl_line_n), .hardscan_control(hardscan_control),
    .entry_total(entry_total), .scan_running(scan_running));
`default_nettype wire

//--- verification/chsq_daq_model.sv
// Purpose: Acquisition board model that writes words over the serial link.
// Assumes: Link half period of four system clocks, 400 ns per bit.
// Notes: Released lines show inverted values so stale data never passes.
`timescale 1ns/100ps
`default_nettype none
module chsq_daq_model (
    input wire logic clock,
    output var logic [3:0] slot_select,
    output var logic frame_line,
    output var logic serial_clock,
    output var logic serial_data
);
    initial begin
        slot_select = 4'h0;
        frame_line = 1'b0;
        serial_clock = 1'b1;
        serial_data = 1'b0;
    end
    task automatic send(input logic [3:0] slot, input logic [15:0] word, input int n);
        @(posedge clock);
        #1 slot_select = slot;
        repeat (4) @(posedge clock);
        #1 frame_line = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            repeat (4) @(posedge clock);
            #1 serial_data = word[i];
            serial_clock = 1'b0;
            repeat (4) @(posedge clock);
            #1 serial_clock = 1'b1;
        end
        repeat (4) @(posedge clock);
        #1 frame_line = 1'b0;
        repeat (10) @(posedge clock);
        #1 slot_select = ~slot;
        serial_data = ~serial_data;
    endtask : send
endmodule : chsq_daq_model
`default_nettype wire

//--- verification/testbench.sv
// Purpose: Self-checking bench for the hardscan sequencer.
// Assumes: Link and trigger are slow against the 50 ns clock.
// Notes: The full-list fill dominates the run time.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic trigger_line = 1'b0;
    logic [3:0] slot_select;
    logic frame_line, serial_clock, serial_data, scan_running;
    logic [15:0] scan_ctrl_line_n;
    logic [7:0] hardscan_control;
    logic [8:0] entry_total;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #25 clock = ~clock;
    chsq_daq_model u_chsq_daq_model (.clock(clock), .slot_select(slot_select), .frame_line(frame_line),
        .serial_clock(serial_clock), .serial_data(serial_data));
    chsq_sequencer u_chsq_sequencer (.clock(clock), .rstn(rstn), .slot_select(slot_select),
        .frame_line(frame_line), .serial_clock(serial_clock), .serial_data(serial_data),
        .trigger_line(trigger_line), .scan_ctrl_line_n(scan_ctrl_line_n), .hardscan_control(hardscan_control),
        .entry_total(entry_total), .scan_running(scan_running));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic ctrl(input logic [7:0] v);
        u_chsq_daq_model.send(4'hd, {8'h00, v}, 8);
    endtask : ctrl
    task automatic trig(input int n);
        repeat (n) begin
            trigger_line = 1'b1;
            repeat (4) @(posedge clock);
            #1 trigger_line = 1'b0;
            repeat (4) @(posedge clock);
            #1;
        end
    endtask : trig
    task automatic t_refuse();
        u_chsq_daq_model.send(4'he, 16'h0282, 8);
        u_chsq_daq_model.send(4'hd, 16'h00ff, 16);
        u_chsq_daq_model.send(4'h3, 16'h0282, 16);
        check(16'(hardscan_control), 16'h004c);
        check(16'(entry_total), 16'h0000);
        $display("refuse done");
    endtask : t_refuse
    task automatic t_scan();
        // Upper bits set on the first entry must be ignored.
        u_chsq_daq_model.send(4'he, 16'hfa82, 16);
        u_chsq_daq_model.send(4'he, 16'h0100, 16);
        check(16'(entry_total), 16'h0002);
        ctrl(8'h7b);
        check(scan_ctrl_line_n, ~16'h0040);
        trig(2);
        check(scan_ctrl_line_n, ~16'h0040);
        trig(1);
        check(scan_ctrl_line_n, ~16'h0008);
        trig(1);
        check(16'(scan_running), 16'h0000);
        $display("scan done");
    endtask : t_scan
    task automatic t_gate();
        logic [7:0] codes[2] = '{8'h6a, 8'h4b};
        // A rewind only proves itself while a scan is live and the read position is off the first entry.
        ctrl(8'h6a);
        check(16'(scan_running), 16'h0001);
        check(scan_ctrl_line_n, ~16'h0008);
        ctrl(8'h3f);
        check(16'(scan_running), 16'h0000);
        foreach (codes[k]) begin
            ctrl(codes[k]);
            trig(3);
            check(scan_ctrl_line_n, ~16'h0040);
        end
        ctrl(8'h6b);
        trig(4);
        check(scan_ctrl_line_n, ~16'h0040);
        ctrl(8'h69);
        check(scan_ctrl_line_n, 16'hffff);
        ctrl(8'h77);
        check(16'(entry_total), 16'h0000);
        $display("gate done");
    endtask : t_gate
    task automatic t_fill();
        ctrl(8'h4c);
        repeat (257) u_chsq_daq_model.send(4'he, 16'h0000, 16);
        check(16'(entry_total), 16'h0100);
        $display("fill done");
    endtask : t_fill
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #4000000 n_mismatch++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clock);
        #1 rstn = 1'b1;
        check(16'(hardscan_control), 16'h004c);
        t_refuse();
        t_scan();
        t_gate();
        t_fill();
        final_report();
    end
endmodule : testbench
`default_nettype wire
